/* File: mscd_params.svh */
// Purpose: Offsets, field positions, reset values and counts for the stop/division block
// Assumes: 32-bit APB data, registers on aligned words, low 16 bits used
// Notes:   Definitions only
`ifndef MSCD_PARAMS_SVH
`define MSCD_PARAMS_SVH

// Register byte offsets
`define MSCD_OFS_MSTOP      12'h000
`define MSCD_OFS_EXT        12'h004
`define MSCD_OFS_SCK        12'h008
`define MSCD_OFS_SBY        12'h00C
`define MSCD_OFS_SLEEP      12'h010
`define MSCD_OFS_STATUS     12'h014

// Reset values and required patterns
`define MSCD_MSTOP_RST      16'h0FFF
`define MSCD_EXT_RST        16'hFFFD
`define MSCD_EXT_ALLSTOP    16'hFFFF

// Stop bits covered by the all-clocks-stop check, with and without the 8-bit timer
`define MSCD_ALL_MASK       16'h3D7F
`define MSCD_NOTMR_MASK     16'h3D7E

// Field positions
`define MSCD_ALL_CLOCKS_STOP_ENABLE_BIT       15
`define MSCD_TMR_BIT        0
`define MSCD_STANDBY_SELECT_BIT       0
`define MSCD_SLEEP_BIT      0
`define MSCD_SCK_W          3

// Counts
`define MSCD_NUM_GATES      14
`define MSCD_DIV_CNT_W      2

`endif

/* File: mscd_pkg.sv */
// Purpose: Types shared by the stop/division block
// Assumes: Nothing beyond SystemVerilog
// Notes:   Encodings are written out so status reads are stable
package mscd_pkg;

    // Power state of the device
    typedef enum logic [2:0] {
        MSCD_RUN     = 3'b000,
        MSCD_SLEEP   = 3'b001,
        MSCD_SSTBY   = 3'b010,
        MSCD_ALLSTOP = 3'b011,
        MSCD_HSTBY   = 3'b100
    } mscd_pwr_e;

    // Operating clock ratio
    typedef enum logic [1:0] {
        MSCD_DIV1 = 2'b00,
        MSCD_DIV2 = 2'b01,
        MSCD_DIV4 = 2'b10
    } mscd_div_e;

endpackage

/* File: mscd_clk_div.sv */
// Purpose: Operating clock tick at full, half or quarter rate
// Assumes: Ratio changes only at bus-cycle ends, decided upstream
// Notes:   Tick is a one-cycle pulse from a flip-flop
`include "mscd_params.svh"

module mscd_clk_div
    import mscd_pkg::*;
#(
    parameter int CNT_W = `MSCD_DIV_CNT_W
) (
    input  wire logic      pclk,
    input  wire logic      presetn,
    input  wire logic      clear,
    input  wire mscd_div_e ratio,
    output logic           tick
);

    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] mask;

    // Quarter rate needs two counter bits at least
    if (CNT_W < 2) begin : g_chk
        $error("mscd_clk_div: CNT_W must be at least 2");
    end

    // Counter bits that must be zero for a tick
    always_comb begin
        mask = '0;
        case (ratio)
            MSCD_DIV2: mask[0] = 1'b1;
            MSCD_DIV4: mask[1:0] = 2'b11;
            default:   mask = '0;
        endcase
    end

    // Free-running phase counter, restarted by a clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg <= '0;
        end else if (clear) begin
            cnt_reg <= '0;
        end else begin
            cnt_reg <= cnt_reg + 1'b1;
        end
    end

    // Registered tick; full rate ticks every cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick <= 1'b0;
        end else begin
            tick <= ((cnt_reg & mask) == '0);
        end
    end

endmodule

/* File: mscd_top.sv */
// Purpose: Module stop gating, clock division and low-power state control
// Assumes: APB slave on pclk; pins pass two flip-flops; wdt and bus-end inputs are on pclk
// Notes:   Gate order on module_clk_en is dma, dtc, tpu, ppg, da23, ad, serial 0..4, tmr, i2c 0, i2c 1
//
// Behaviour
// RQ1: Stop bit one stops module, zero resumes
// RQ2: Bit 15 enables all-clocks-stop on sleep
// RQ3: Upper stop bits map dma, dtc, tpu, ppg, da
// RQ4: Lower stop bits map ad, serial, 8-bit timer
// RQ5: Software sets extension register per all-stop use
// RQ6: Reserved extension bits readable, writable, reset one; here bit 1 resets to zero (reset value FFFD)
// RQ7: Extension bits 4 and 3 stop i2c
// RQ8: Division takes effect at bus cycle end
// RQ9: Everything runs from the selected divided clock
// RQ10: Zero select returns full speed at cycle end
// RQ11: Sleep when standby-select clear; division kept
// RQ12: Software standby when set; division kept
// RQ13: Reset pin or watchdog clears division
// RQ14: Hardware standby pin low forces standby
// RQ15: Stopped module clock gated, resumes on clear
//
// Local design decisions: the placing of the registers and the APB slave port.
`include "mscd_params.svh"

module mscd_top
    import mscd_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [ADDR_W-1:0]          paddr,
    input  wire logic [31:0]                pwdata,
    output logic      [31:0]                prdata,
    output logic                            pready,
    output logic                            pslverr,
    input  wire logic                       bus_cycle_end,
    input  wire logic                       irq_wake,
    input  wire logic                       ext_irq_wake,
    input  wire logic                       watchdog_overflow,
    input  wire logic                       external_reset_pin_n,
    input  wire logic                       hardware_standby_pin_n,
    output logic                            cpu_clk_en,
    output logic                            bus_master_clk_en,
    output logic [`MSCD_NUM_GATES-1:0]      module_clk_en,
    output logic                            osc_stop,
    output mscd_pwr_e                       pwr_state
);

    logic [15:0]             mstop_reg;
    logic [15:0]             ext_reg;
    logic [`MSCD_SCK_W-1:0]  sck_reg;
    logic                    standby_select_reg;
    mscd_div_e               div_reg;
    mscd_pwr_e               state_reg;
    mscd_pwr_e               state_next;
    logic [1:0]              pin_meta_reg;
    logic [1:0]              pin_sync_reg;
    logic                    rst_pin_low;
    logic                    hstby_low;
    logic                    soft_clear;
    logic                    setup_ph;
    logic                    wr_en;
    logic                    sleep_cmd;
    logic                    allstop_ok;
    logic                    sck_legal;
    logic                    tick;
    logic                    periph_run;
    logic [31:0]             stop_vec;
    logic [31:0]             rd_mux;
    logic                    rd_hit;
    logic [11:0]             reg_ofs;
    logic                    addr_hit;

    // Six offset bits plus at least one upper bit that must decode as zero
    if (ADDR_W < 7) begin : g_chk
        $error("mscd_top: ADDR_W must be at least 7");
    end

    // Two flops on each pin; only the second stage is looked at
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_meta_reg <= 2'b11;
            pin_sync_reg <= 2'b11;
        end else begin
            pin_meta_reg <= {hardware_standby_pin_n, external_reset_pin_n};
            pin_sync_reg <= pin_meta_reg;
        end
    end

    // Reset pin, watchdog overflow and hardware standby all put functions in reset
    assign rst_pin_low = !pin_sync_reg[0];
    assign hstby_low   = !pin_sync_reg[1];
    assign soft_clear  = rst_pin_low || watchdog_overflow || hstby_low; // [RQ13] [RQ14]

    // Offset within the decoded window; any upper address bit set is a miss,
    // so aliases of a register can never be written
    assign reg_ofs   = {6'h00, paddr[5:0]};
    assign addr_hit  = (paddr[ADDR_W-1:6] == '0);

    // APB phases; zero wait states, so the access edge is the write edge
    assign setup_ph  = psel && !penable;
    assign wr_en     = psel && penable && pwrite && addr_hit;
    assign pready    = 1'b1;
    assign sleep_cmd = wr_en && (reg_ofs == `MSCD_OFS_SLEEP) && pwdata[`MSCD_SLEEP_BIT];

    // Prohibited select codes 110 and 111 leave the field unchanged
    assign sck_legal = (pwdata[`MSCD_SCK_W-1:0] <= 3'b101);

    // Module stop register; soft reset restores the power-up pattern
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mstop_reg <= `MSCD_MSTOP_RST;
        end else if (soft_clear) begin
            mstop_reg <= `MSCD_MSTOP_RST;
        end else if (wr_en && reg_ofs == `MSCD_OFS_MSTOP) begin
            mstop_reg <= pwdata[15:0]; // [RQ1] [RQ2]
        end
    end

    // Extension register; reserved bits are stored as written, reset to ones except bit 1
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_reg <= `MSCD_EXT_RST;
        end else if (soft_clear) begin
            ext_reg <= `MSCD_EXT_RST; // [RQ6]
        end else if (wr_en && reg_ofs == `MSCD_OFS_EXT) begin
            ext_reg <= pwdata[15:0]; // [RQ6]
        end
    end

    // Clock select and standby select
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sck_reg  <= '0;
            standby_select_reg <= 1'b0;
        end else if (soft_clear) begin
            sck_reg  <= '0; // [RQ13]
            standby_select_reg <= 1'b0;
        end else begin
            if (wr_en && reg_ofs == `MSCD_OFS_SCK && sck_legal) begin
                sck_reg <= pwdata[`MSCD_SCK_W-1:0];
            end
            if (wr_en && reg_ofs == `MSCD_OFS_SBY) begin
                standby_select_reg <= pwdata[`MSCD_STANDBY_SELECT_BIT];
            end
        end
    end

    // Active ratio follows the select field only at a bus-cycle end, so a
    // transfer in flight never sees its clock change under it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_reg <= MSCD_DIV1;
        end else if (soft_clear) begin
            div_reg <= MSCD_DIV1; // [RQ13]
        end else if (bus_cycle_end) begin
            case (sck_reg)
                3'b000:  div_reg <= MSCD_DIV1; // [RQ10]
                3'b001:  div_reg <= MSCD_DIV2; // [RQ8]
                default: div_reg <= MSCD_DIV4; // [RQ8]
            endcase
        end
    end

    // All-clocks-stop needs the enable, every gated module (timer may run)
    // and the extension register at its all-ones pattern
    assign allstop_ok = mstop_reg[`MSCD_ALL_CLOCKS_STOP_ENABLE_BIT]
                        && ((mstop_reg & `MSCD_NOTMR_MASK) == `MSCD_NOTMR_MASK) // [RQ2]
                        && (ext_reg == `MSCD_EXT_ALLSTOP); // [RQ5]

    // Power state selection; outside hardware standby the ratio register is untouched on entry
    // and exit, which is what brings division back on wake-up
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            MSCD_RUN: begin
                if (sleep_cmd && standby_select_reg) begin
                    state_next = MSCD_SSTBY; // [RQ12]
                end else if (sleep_cmd && allstop_ok) begin
                    state_next = MSCD_ALLSTOP; // [RQ2]
                end else if (sleep_cmd) begin
                    state_next = MSCD_SLEEP; // [RQ11]
                end
            end
            MSCD_SLEEP, MSCD_ALLSTOP: begin
                if (irq_wake) begin
                    state_next = MSCD_RUN; // [RQ11]
                end
            end
            MSCD_SSTBY: begin
                if (ext_irq_wake) begin
                    state_next = MSCD_RUN; // [RQ12]
                end
            end
            MSCD_HSTBY: begin
                state_next = MSCD_RUN;
            end
            default: state_next = MSCD_RUN;
        endcase
        if (hstby_low) begin
            state_next = MSCD_HSTBY; // [RQ14]
        end else if (rst_pin_low || watchdog_overflow) begin
            state_next = MSCD_RUN; // [RQ13]
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= MSCD_RUN;
        end else begin
            state_reg <= state_next;
        end
    end

    // Operating clock tick at the active ratio
    mscd_clk_div #(
        .CNT_W   (`MSCD_DIV_CNT_W)
    ) u_div (
        .pclk    (pclk),
        .presetn (presetn),
        .clear   (soft_clear),
        .ratio   (div_reg),
        .tick    (tick)
    );

    // CPU only in run; masters also in sleep; peripherals stop in standby
    assign cpu_clk_en        = tick && (state_reg == MSCD_RUN) && !soft_clear; // [RQ9]
    assign bus_master_clk_en = tick && (state_reg == MSCD_RUN || state_reg == MSCD_SLEEP) && !soft_clear; // [RQ9]
    assign periph_run        = (state_reg == MSCD_RUN) || (state_reg == MSCD_SLEEP)
                               || (state_reg == MSCD_ALLSTOP);
    assign osc_stop          = (state_reg == MSCD_SSTBY) || (state_reg == MSCD_HSTBY);
    assign pwr_state         = state_reg;
    assign stop_vec          = {ext_reg, mstop_reg};

    // One gate per peripheral; a gated module keeps its registers since only
    // its enable drops, and it resumes on the first tick after the clear.
    // In all-clocks-stop only the timer may keep running.
    localparam int GATE_BIT [`MSCD_NUM_GATES] = '{13, 12, 11, 10, 8, 6, 1, 2, 3, 4, 5, 0, 19, 20};
    for (genvar g = 0; g < `MSCD_NUM_GATES; g++) begin : g_gate
        if (GATE_BIT[g] == `MSCD_TMR_BIT) begin : g_tmr
            assign module_clk_en[g] = tick && periph_run && !stop_vec[GATE_BIT[g]]; // [RQ4] [RQ15]
        end else begin : g_std
            assign module_clk_en[g] = tick && periph_run && (state_reg != MSCD_ALLSTOP)
                                      && !stop_vec[GATE_BIT[g]]; // [RQ1] [RQ3] [RQ7] [RQ15]
        end
    end

    // Read mux; unmapped offsets return zero with an error
    always_comb begin
        rd_mux = 32'h0000_0000;
        rd_hit = 1'b1;
        case (reg_ofs)
            `MSCD_OFS_MSTOP:  rd_mux[15:0] = mstop_reg;
            `MSCD_OFS_EXT:    rd_mux[15:0] = ext_reg;
            `MSCD_OFS_SCK:    rd_mux[`MSCD_SCK_W-1:0] = sck_reg;
            `MSCD_OFS_SBY:    rd_mux[`MSCD_STANDBY_SELECT_BIT] = standby_select_reg;
            `MSCD_OFS_SLEEP:  rd_mux = 32'h0000_0000;
            `MSCD_OFS_STATUS: rd_mux[5:0] = {allstop_ok, div_reg, state_reg};
            default:          rd_hit = 1'b0;
        endcase
        if (!addr_hit) begin
            rd_hit = 1'b0;
            rd_mux = 32'h0000_0000;
        end
    end

    // Read data and error captured in the setup cycle, valid in the access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (setup_ph) begin
            prdata  <= pwrite ? 32'h0000_0000 : rd_mux;
            pslverr <= !rd_hit;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Writes land in the stop register
    stop_write_a: assert property (wr_en && reg_ofs == `MSCD_OFS_MSTOP && !soft_clear // [RQ1]
        |=> mstop_reg == $past(pwdata[15:0]))
        else $error("stop register write lost");

    // Reset sources restore full speed and reset pattern
    reset_clear_a: assert property (soft_clear // [RQ13]
        |=> div_reg == MSCD_DIV1 && mstop_reg == `MSCD_MSTOP_RST && ext_reg == `MSCD_EXT_RST)
        else $error("soft reset did not clear state");

    // Ratio never changes except after a bus-cycle end or reset
    div_boundary_a: assert property (!bus_cycle_end && !soft_clear |=> $stable(div_reg)) // [RQ8]
        else $error("ratio changed inside a bus cycle");

    // Zero select returns full speed at the cycle end
    div_zero_a: assert property (sck_reg == 3'b000 && bus_cycle_end |=> div_reg == MSCD_DIV1) // [RQ10]
        else $error("full speed not restored");

    // Sleep entry choice
    sleep_entry_a: assert property (state_reg == MSCD_RUN && sleep_cmd && !standby_select_reg && !allstop_ok // [RQ11]
        && !soft_clear |=> state_reg == MSCD_SLEEP && $stable(div_reg))
        else $error("sleep not entered");

    standby_entry_a: assert property (state_reg == MSCD_RUN && sleep_cmd && standby_select_reg && !soft_clear // [RQ12]
        |=> state_reg == MSCD_SSTBY ##1 (state_reg == MSCD_SSTBY || $past(ext_irq_wake) || $past(soft_clear)))
        else $error("software standby not held");

    allstop_entry_a: assert property (state_reg == MSCD_RUN && sleep_cmd && !standby_select_reg && allstop_ok // [RQ2]
        && !soft_clear |=> state_reg == MSCD_ALLSTOP && module_clk_en[0] == 1'b0)
        else $error("all-clocks-stop not entered");

    hw_standby_a: assert property (hstby_low |=> state_reg == MSCD_HSTBY && osc_stop) // [RQ14]
        else $error("hardware standby not entered");

    dma_gate_a: assert property (mstop_reg[13] |-> !module_clk_en[0]) // [RQ3]
        else $error("dma clock not gated");

    tmr_gate_a: assert property (mstop_reg[0] |-> !module_clk_en[11]) // [RQ4]
        else $error("timer clock not gated");

    i2c_gate_a: assert property (ext_reg[3] || ext_reg[4] |-> !(module_clk_en[12] && ext_reg[3]) // [RQ7]
        && !(module_clk_en[13] && ext_reg[4]))
        else $error("i2c clock not gated");

    ungate_a: assert property (state_reg == MSCD_RUN && !soft_clear && $fell(mstop_reg[12]) // [RQ15]
        |-> ##[0:4] module_clk_en[1])
        else $error("module clock not resumed");

    // Prohibited select codes leave the field alone
    sck_reject_a: assert property (wr_en && reg_ofs == `MSCD_OFS_SCK && !sck_legal && !soft_clear // [RQ8]
        |=> $stable(sck_reg))
        else $error("prohibited clock select stored");

    // Only the timer may run in all-clocks-stop
    allstop_tmr_a: assert property (state_reg == MSCD_ALLSTOP |-> module_clk_en[10:0] == '0 // [RQ2]
        && module_clk_en[13:12] == '0)
        else $error("clock left running in all-clocks-stop");

    // CPU clock only while running
    cpu_halt_a: assert property (state_reg != MSCD_RUN |-> !cpu_clk_en) // [RQ11]
        else $error("cpu clock running while halted");

    // Software standby stops every peripheral clock
    standby_gate_a: assert property (state_reg == MSCD_SSTBY |-> osc_stop && module_clk_en == '0) // [RQ12]
        else $error("clock running in software standby");

endmodule

/* File: mscd_top_test.sv */
// Purpose: Self-checking bench for the module stop and clock division block
// Assumes: Zero-wait APB slave; pins pass a two-flop synchroniser inside
// Notes:   Enable pulses are counted over 8 or 16 cycles, multiples of every ratio period
`include "mscd_params.svh"

`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin err_total++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, (got), (exp)); end end

module mscd_top_test
    import mscd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic            pclk;
    logic            presetn;
    logic            psel;
    logic            penable;
    logic            pwrite;
    logic [11:0]     paddr;
    logic [31:0]     pwdata;
    logic [31:0]     prdata;
    logic            pready;
    logic            pslverr;
    logic            bus_cycle_end;
    logic            irq_wake;
    logic            ext_irq_wake;
    logic            watchdog_overflow;
    logic            external_reset_pin_n;
    logic            hardware_standby_pin_n;
    logic            cpu_clk_en;
    logic            bus_master_clk_en;
    logic [13:0]     module_clk_en;
    logic            osc_stop;
    mscd_pwr_e       pwr_state;
    logic [31:0]     rdat;
    logic            rerr;
    int              err_total;
    int              compares;
    int              ccnt;
    int              bcnt;
    int              mcnt [14];
    // Stop bit in the module stop register for gate indexes 0..11
    int              sbit [12] = '{13, 12, 11, 10, 8, 6, 1, 2, 3, 4, 5, 0};

    mscd_top dut_u (
        .pclk                   (pclk),
        .presetn                (presetn),
        .psel                   (psel),
        .penable                (penable),
        .pwrite                 (pwrite),
        .paddr                  (paddr),
        .pwdata                 (pwdata),
        .prdata                 (prdata),
        .pready                 (pready),
        .pslverr                (pslverr),
        .bus_cycle_end          (bus_cycle_end),
        .irq_wake               (irq_wake),
        .ext_irq_wake           (ext_irq_wake),
        .watchdog_overflow      (watchdog_overflow),
        .external_reset_pin_n   (external_reset_pin_n),
        .hardware_standby_pin_n (hardware_standby_pin_n),
        .cpu_clk_en             (cpu_clk_en),
        .bus_master_clk_en      (bus_master_clk_en),
        .module_clk_en          (module_clk_en),
        .osc_stop               (osc_stop),
        .pwr_state              (pwr_state)
    );

    // 100 MHz clock
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    // Hang guard; a stuck run still reaches the verdict
    initial begin
        repeat (100000) @(posedge pclk);
        err_total++;
        results();
    end

    task automatic results();
        $display("counts: compares=%0d mismatches=%0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // One APB transfer; request held until pready is seen high at an edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            err_total++;
            results();
        end
        rdat    = prdata;
        rerr    = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // One-cycle strobe; mask bits 0..3 are bus end, wake, external wake, watchdog
    task automatic pulse(input logic [3:0] m);
        @(posedge pclk);
        {watchdog_overflow, ext_irq_wake, irq_wake, bus_cycle_end} <= m;
        @(posedge pclk);
        {watchdog_overflow, ext_irq_wake, irq_wake, bus_cycle_end} <= 4'h0;
    endtask

    // Bounded wait for a power state
    task automatic wait_state(input mscd_pwr_e s);
        int n;
        n = 0;
        compares++;
        while (pwr_state !== s && n < 10) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 10) begin
            $display("ERROR t=%0t got=%h exp=%h", $time, pwr_state, s);
            err_total++;
            results();
        end
    endtask

    // Count enable pulses over a window
    task automatic count(input int n);
        ccnt = 0;
        bcnt = 0;
        foreach (mcnt[j]) mcnt[j] = 0;
        repeat (n) begin
            @(posedge pclk);
            ccnt += int'(cpu_clk_en === 1'b1);
            bcnt += int'(bus_master_clk_en === 1'b1);
            foreach (mcnt[j]) mcnt[j] += int'(module_clk_en[j] === 1'b1);
        end
    endtask

    // Ratio change lands only on a bus cycle end; settle allowance per hand-over
    task automatic set_div(input logic [2:0] code);
        apb(1'b1, `MSCD_OFS_SCK, {29'h0, code});
        pulse(4'h1);
        repeat (6) @(posedge pclk);
    endtask

    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {bus_cycle_end, irq_wake, ext_irq_wake, watchdog_overflow} = '0;
        external_reset_pin_n   = 1'b1;
        hardware_standby_pin_n = 1'b1;
        err_total = 0;
        compares  = 0;
        presetn   = 1'b0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;

        // Reset values, reserved bits, unmapped access
        apb(1'b0, `MSCD_OFS_MSTOP, 32'h0);
        `CHK(rdat[15:0], `MSCD_MSTOP_RST)
        apb(1'b0, `MSCD_OFS_EXT, 32'h0);
        `CHK(rdat[15:0], `MSCD_EXT_RST)
        apb(1'b1, `MSCD_OFS_EXT, 32'hFFFF);
        apb(1'b0, `MSCD_OFS_EXT, 32'h0);
        `CHK(rdat[15:0], 16'hFFFF)
        apb(1'b1, 12'h040, 32'h0);
        `CHK(rerr, 1'b1)
        apb(1'b0, `MSCD_OFS_MSTOP, 32'h0);
        `CHK(rdat[15:0], `MSCD_MSTOP_RST)
        apb(1'b0, 12'h020, 32'h0);
        `CHK({rerr, rdat, pready}, {1'b1, 32'h0, 1'b1})
        $display("test registers done");

        // Walk one running module across every gate
        for (int i = 0; i < 14; i++) begin
            apb(1'b1, `MSCD_OFS_MSTOP, (i < 12) ? (32'h3D7F & ~(32'h1 << sbit[i])) : 32'h3D7F);
            apb(1'b1, `MSCD_OFS_EXT, (i < 12) ? 32'hFFFD : (32'hFFFD & ~(32'h1 << (i - 9))));
            count(8);
            for (int j = 0; j < 14; j++) `CHK(mcnt[j] > 0, j == i)
        end
        $display("test module stop done");

        // Division waits for the bus cycle end
        apb(1'b1, `MSCD_OFS_SCK, 32'h1);
        count(16);
        `CHK(ccnt, 16)
        pulse(4'h1);
        repeat (6) @(posedge pclk);
        count(16);
        `CHK(ccnt, 8)
        `CHK(mcnt[13], 8)
        apb(1'b0, `MSCD_OFS_STATUS, 32'h0);
        `CHK(rdat[4:3], 2'b01)
        apb(1'b1, `MSCD_OFS_SCK, 32'h6);
        apb(1'b0, `MSCD_OFS_SCK, 32'h0);
        `CHK(rdat[2:0], 3'b001)
        set_div(3'b101);
        count(16);
        `CHK(ccnt, 4)
        set_div(3'b000);
        count(16);
        `CHK(ccnt, 16)
        $display("test division done");

        // Sleep and software standby keep the division
        set_div(3'b001);
        apb(1'b1, `MSCD_OFS_SBY, 32'h0);
        apb(1'b1, `MSCD_OFS_SLEEP, 32'h1);
        wait_state(MSCD_SLEEP);
        count(16);
        `CHK({ccnt, bcnt}, {32'd0, 32'd8})
        pulse(4'h2);
        wait_state(MSCD_RUN);
        count(16);
        `CHK(ccnt, 8)
        apb(1'b1, `MSCD_OFS_SBY, 32'h1);
        apb(1'b1, `MSCD_OFS_SLEEP, 32'h1);
        wait_state(MSCD_SSTBY);
        `CHK(osc_stop, 1'b1)
        pulse(4'h4);
        wait_state(MSCD_RUN);
        count(16);
        `CHK(ccnt, 8)
        $display("test low power done");

        // All-clocks-stop needs its enable bit
        apb(1'b1, `MSCD_OFS_SBY, 32'h0);
        apb(1'b1, `MSCD_OFS_MSTOP, 32'h3D7E);
        apb(1'b1, `MSCD_OFS_EXT, 32'hFFFF);
        apb(1'b1, `MSCD_OFS_SLEEP, 32'h1);
        wait_state(MSCD_SLEEP);
        pulse(4'h2);
        wait_state(MSCD_RUN);
        apb(1'b1, `MSCD_OFS_MSTOP, 32'hBD7E);
        apb(1'b1, `MSCD_OFS_SLEEP, 32'h1);
        wait_state(MSCD_ALLSTOP);
        count(16);
        `CHK({mcnt[11], mcnt[0], ccnt}, {32'd8, 32'd0, 32'd0})
        pulse(4'h2);
        wait_state(MSCD_RUN);
        $display("test all stop done");

        // Watchdog, reset pin and standby pin clear the division
        pulse(4'h8);
        repeat (2) @(posedge pclk);
        apb(1'b0, `MSCD_OFS_MSTOP, 32'h0);
        `CHK(rdat[15:0], `MSCD_MSTOP_RST)
        count(16);
        `CHK(ccnt, 16)
        set_div(3'b001);
        external_reset_pin_n <= 1'b0;
        repeat (5) @(posedge pclk);
        external_reset_pin_n <= 1'b1;
        repeat (5) @(posedge pclk);
        apb(1'b0, `MSCD_OFS_SCK, 32'h0);
        `CHK(rdat[2:0], 3'b000)
        count(16);
        `CHK(ccnt, 16)
        set_div(3'b001);
        hardware_standby_pin_n <= 1'b0;
        wait_state(MSCD_HSTBY);
        `CHK(osc_stop, 1'b1)
        hardware_standby_pin_n <= 1'b1;
        wait_state(MSCD_RUN);
        count(16);
        `CHK(ccnt, 16)
        $display("test resets done");
        results();
    end
endmodule
